// ---- core/twc_ctrl.v ----
// two-wire main control register block with APB slave and line control
`timescale 1ns/100ps
`default_nettype none
`include "twc_regs.vh"

module twc_ctrl (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // two-wire pins, oe high pulls the line low
    input  wire        sda_i,
    output reg         sda_o,
    output wire        sda_oe,
    input  wire        scl_i,
    output reg         scl_o,
    output wire        scl_oe,
    // protocol engine drive
    input  wire        eng_sda_pull,
    input  wire        eng_scl_pull,
    // protocol engine events
    input  wire        eng_byte_rx,
    input  wire        eng_gc_seen,
    // protocol engine control
    output reg         engine_enable,
    output reg         controller_role,
    output reg         irx_active,
    // replies to the engine
    output wire        byte_reply_valid,
    output wire        byte_reply_nack,
    output wire        gc_reply_valid,
    output wire        gc_reply_ack
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function addr_hit;
        input [11:0] addr;
        input [11:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = addr_hit(addr, `TWC_MAIN_CTRL_ADDR) |
                     addr_hit(addr, `TWC_BUS_STATE_ADDR);
        end
    endfunction

    // control word as software reads it: stored fields plus live pin levels
    function [31:0] ctrl_view;
        input [31:0] stored;
        input        sda_lvl;
        input        scl_lvl;
        begin
            ctrl_view = stored;
            ctrl_view[`TWC_SDA_LVL_BIT] = sda_lvl;
            ctrl_view[`TWC_SCL_LVL_BIT] = scl_lvl;
        end
    endfunction

    function [31:0] state_view;
        input busy;
        input misuse;
        begin
            state_view = `TWC_STATE_RST;
            state_view[`TWC_BUSY_BIT]   = busy;
            state_view[`TWC_MISUSE_BIT] = misuse;
        end
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    reg  [31:0] ctrl_reg;
    reg  [31:0] ctrl_next;
    reg  [1:0]  line_state_reg;
    reg  [1:0]  line_state_next;
    reg         misuse_reg;
    reg         misuse_next;
    reg         sda_prev_reg;
    reg         scl_prev_reg;
    reg  [31:0] rdata_next;
    reg         pready_next;
    reg         pslverr_next;

    wire        setup_phase;
    wire        access_done;
    wire        wr_ctrl;
    wire        wr_state;
    wire        start_seen;
    wire        stop_seen;
    wire        irx_changed;
    wire        line_busy;

    wire        f_en;
    wire        f_role;
    wire        f_gc;
    wire        f_irx_en;
    wire        f_irx_ack;
    wire        f_scl_out;
    wire        f_sda_out;
    wire        f_swpin;

    assign f_en      = ctrl_reg[`TWC_EN_BIT];
    assign f_role    = ctrl_reg[`TWC_ROLE_BIT];
    assign f_gc      = ctrl_reg[`TWC_GC_BIT];
    assign f_irx_en  = ctrl_reg[`TWC_IRX_EN_BIT];
    assign f_irx_ack = ctrl_reg[`TWC_IRX_ACK_BIT];
    assign f_scl_out = ctrl_reg[`TWC_SCL_OUT_BIT];
    assign f_sda_out = ctrl_reg[`TWC_SDA_OUT_BIT];
    assign f_swpin   = ctrl_reg[`TWC_SWPIN_BIT];

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_ctrl     = access_done & pwrite & addr_hit(paddr, `TWC_MAIN_CTRL_ADDR);
    assign wr_state    = access_done & pwrite & addr_hit(paddr, `TWC_BUS_STATE_ADDR);

    // zero wait states: pready answers every setup cycle
    always @* begin
        pready_next  = setup_phase;
        pslverr_next = setup_phase & ~mapped(paddr);
        rdata_next   = 32'h0000_0000;
        if (setup_phase & ~pwrite) begin
            if (addr_hit(paddr, `TWC_MAIN_CTRL_ADDR)) begin
                rdata_next = ctrl_view(ctrl_reg, sda_i, scl_i);
            end else if (addr_hit(paddr, `TWC_BUS_STATE_ADDR)) begin
                rdata_next = state_view(line_busy, misuse_reg);
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= pready_next;
            pslverr <= pslverr_next;
            // prdata holds between transfers
            if (setup_phase) begin
                prdata <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------------------
    // main control register
    // ------------------------------------------------------------------------
    always @* begin
        ctrl_next = ctrl_reg;
        // reserved and read-only bits are dropped on write
        if (wr_ctrl) begin
            ctrl_next = pwdata & `TWC_CTRL_WMASK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `TWC_CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------------------
    // bus activity monitor
    // ------------------------------------------------------------------------
    localparam [1:0] LINE_IDLE   = 2'b01;
    localparam [1:0] LINE_ACTIVE = 2'b10;

    // start: sda falls while scl stays high; stop: sda rises while scl stays high
    assign start_seen = sda_prev_reg & ~sda_i & scl_prev_reg & scl_i;
    assign stop_seen  = ~sda_prev_reg & sda_i & scl_prev_reg & scl_i;
    assign line_busy  = (line_state_reg == LINE_ACTIVE);

    // a repeated start leaves the bus active until the stop
    always @* begin
        line_state_next = line_state_reg;
        case (line_state_reg)
            LINE_IDLE: begin
                if (start_seen) begin
                    line_state_next = LINE_ACTIVE;
                end
            end
            LINE_ACTIVE: begin
                if (stop_seen) begin
                    line_state_next = LINE_IDLE;
                end
            end
            default: begin
                line_state_next = LINE_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_prev_reg   <= 1'b1;
            scl_prev_reg   <= 1'b1;
            line_state_reg <= LINE_IDLE;
        end else begin
            sda_prev_reg   <= sda_i;
            scl_prev_reg   <= scl_i;
            line_state_reg <= line_state_next;
        end
    end

    // ------------------------------------------------------------------------
    // interactive receive misuse flag
    // ------------------------------------------------------------------------
    // interactive mode toggled while a transfer is on the bus
    assign irx_changed = wr_ctrl & line_busy &
                         (pwdata[`TWC_IRX_EN_BIT] != f_irx_en);

    always @* begin
        misuse_next = misuse_reg;
        if (wr_state & pwdata[`TWC_MISUSE_BIT]) begin
            misuse_next = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (irx_changed) begin
            misuse_next = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misuse_reg <= 1'b0;
        end else begin
            misuse_reg <= misuse_next;
        end
    end

    // ------------------------------------------------------------------------
    // engine control outputs
    // ------------------------------------------------------------------------
    // the engine sees the fields one cycle after the write lands
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engine_enable   <= 1'b0;
            controller_role <= 1'b0;
            irx_active      <= 1'b0;
            sda_o           <= 1'b0;
            scl_o           <= 1'b0;
        end else begin
            engine_enable   <= f_en;
            controller_role <= f_en & f_role;
            irx_active      <= f_en & f_irx_en;
            sda_o           <= 1'b0;
            scl_o           <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // line drive and replies
    // ------------------------------------------------------------------------
    // replies are muted while the engine is off
    twc_pin_mux u_pin_mux (
        .pclk         (pclk),
        .presetn      (presetn),
        .sw_pin_ctrl  (f_swpin),
        .sw_sda_level (f_sda_out),
        .sw_scl_level (f_scl_out),
        .engine_on    (f_en),
        .eng_sda_pull (eng_sda_pull),
        .eng_scl_pull (eng_scl_pull),
        .sda_oe       (sda_oe),
        .scl_oe       (scl_oe)
    );

    twc_ack_sel u_ack_sel (
        .pclk             (pclk),
        .presetn          (presetn),
        .engine_on        (f_en),
        .irx_enable       (f_irx_en),
        .irx_nack         (f_irx_ack),
        .gc_accept        (f_gc),
        .eng_byte_rx      (eng_byte_rx),
        .eng_gc_seen      (eng_gc_seen),
        .byte_reply_valid (byte_reply_valid),
        .byte_reply_nack  (byte_reply_nack),
        .gc_reply_valid   (gc_reply_valid),
        .gc_reply_ack     (gc_reply_ack)
    );

endmodule // twc_ctrl

`default_nettype wire

// ---- core/twc_regs.vh ----
// register map, field positions and reset values of the two-wire control block
// Notes on behaviour
// - A zero in the data-line drive field pulls SDA low and a one releases it to float high.
// - The clock-line drive field at bit 6 pulls SCL low when zero and releases it when one.
// - The two drive fields reach the pins only under software pin control, else the engine drives while enabled and both lines float while it is off.
// - With interactive receive on, each received byte is answered ACK if bit 4 is 0, NACK if 1.
// - Bit 3 set lets software pick the reply to each received byte; clear turns that mode off.
// - With bit 2 set the general call address is acknowledged, with it clear it is ignored.
// - Bit 1 selects target role at 0 and controller role at 1.
// - Setting software pin control hands both lines to the drive fields, clearing hands them back.
`ifndef TWC_REGS_VH
`define TWC_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define TWC_ADDR_W          12
`define TWC_MAIN_CTRL_ADDR  12'h000
`define TWC_BUS_STATE_ADDR  12'h060

// ----------------------------------------------------------------------------
// main control fields
// ----------------------------------------------------------------------------
`define TWC_EN_BIT          0
`define TWC_ROLE_BIT        1
`define TWC_GC_BIT          2
`define TWC_IRX_EN_BIT      3
`define TWC_IRX_ACK_BIT     4
`define TWC_SCL_OUT_BIT     6
`define TWC_SDA_OUT_BIT     7
`define TWC_SCL_LVL_BIT     8
`define TWC_SDA_LVL_BIT     9
`define TWC_SWPIN_BIT       10
`define TWC_CTRL_WMASK      32'h0000_04DF
`define TWC_CTRL_RST        32'h0000_0000

// ----------------------------------------------------------------------------
// bus state fields
// ----------------------------------------------------------------------------
`define TWC_BUSY_BIT        0
`define TWC_MISUSE_BIT      1
`define TWC_STATE_RST       32'h0000_0000

`endif

// ---- core/twc_pin_mux.v ----
// line driver select between protocol engine and software drive fields
`timescale 1ns/100ps
`default_nettype none

module twc_pin_mux (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // control
    input  wire sw_pin_ctrl,
    input  wire sw_sda_level,
    input  wire sw_scl_level,
    input  wire engine_on,
    // engine drive, high pulls the line low
    input  wire eng_sda_pull,
    input  wire eng_scl_pull,
    // pin drive, open drain
    output reg  sda_oe,
    output reg  scl_oe
);

    reg sda_oe_next;
    reg scl_oe_next;

    // ------------------------------------------------------------------------
    // drive selection
    // ------------------------------------------------------------------------
    always @* begin
        if (sw_pin_ctrl) begin
            sda_oe_next = ~sw_sda_level;
            scl_oe_next = ~sw_scl_level;
        end else if (engine_on) begin
            sda_oe_next = eng_sda_pull;
            scl_oe_next = eng_scl_pull;
        end else begin
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            sda_oe <= sda_oe_next;
            scl_oe <= scl_oe_next;
        end
    end

endmodule // twc_pin_mux

`default_nettype wire

// ---- core/twc_ack_sel.v ----
// reply selection for received bytes and the general call address
`timescale 1ns/100ps
`default_nettype none

module twc_ack_sel (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // control
    input  wire engine_on,
    input  wire irx_enable,
    input  wire irx_nack,
    input  wire gc_accept,
    // engine events
    input  wire eng_byte_rx,
    input  wire eng_gc_seen,
    // replies to the engine
    output reg  byte_reply_valid,
    output reg  byte_reply_nack,
    output reg  gc_reply_valid,
    output reg  gc_reply_ack
);

    // ------------------------------------------------------------------------
    // reply registers
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_reply_valid <= 1'b0;
            byte_reply_nack  <= 1'b0;
            gc_reply_valid   <= 1'b0;
            gc_reply_ack     <= 1'b0;
        end else begin
            byte_reply_valid <= engine_on & eng_byte_rx;
            gc_reply_valid   <= engine_on & eng_gc_seen;
            if (engine_on & eng_byte_rx) begin
                // without interactive mode the engine always acknowledges
                byte_reply_nack <= irx_enable & irx_nack;
            end
            if (engine_on & eng_gc_seen) begin
                gc_reply_ack <= gc_accept;
            end
        end
    end

endmodule // twc_ack_sel

`default_nettype wire

// ---- test/twc_bus_model.sv ----
// far side of the two-wire bus: pull-ups and other devices pulling low
`timescale 1ns/100ps
`default_nettype none

module twc_bus_model (
    // block drive, high pulls low
    input  wire logic sda_oe,
    input  wire logic scl_oe,
    // other devices on the bus
    input  wire logic far_sda_pull,
    input  wire logic far_scl_pull,
    // resolved line levels
    output wire logic sda_i,
    output wire logic scl_i
);
    // a released line is pulled high
    assign sda_i = !(sda_oe || far_sda_pull);
    assign scl_i = !(scl_oe || far_scl_pull);
endmodule // twc_bus_model

`default_nettype wire

// ---- test/twc_ctrl_asserts.sv ----
// port checker for the two-wire control block
`timescale 1ns/100ps
`default_nettype none
`include "twc_regs.vh"

module twc_ctrl_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic        sda_o,
    input wire logic        scl_o,
    // engine side
    input wire logic        eng_byte_rx,
    input wire logic        eng_gc_seen,
    input wire logic        engine_enable,
    input wire logic        controller_role,
    input wire logic        irx_active,
    input wire logic        byte_reply_valid,
    input wire logic        byte_reply_nack,
    input wire logic        gc_reply_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_rd;
        s_setup ##0 (!pwrite && paddr != `TWC_MAIN_CTRL_ADDR && paddr != `TWC_BUS_STATE_ADDR);
    endsequence
    property p_ready_after_setup;
        s_setup |=> pready;
    endproperty
    property p_ready_cause;
        pready |-> $past(psel && !penable);
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_bad_read;
        s_bad_rd |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_open_drain;
        sda_o == 1'b0 && scl_o == 1'b0;
    endproperty
    property p_byte_reply;
        byte_reply_valid |-> $past(eng_byte_rx);
    endproperty
    property p_gc_reply;
        gc_reply_valid |-> $past(eng_gc_seen);
    endproperty
    property p_nack_irx;
        byte_reply_valid && byte_reply_nack |-> irx_active;
    endproperty
    property p_role_en;
        controller_role || irx_active |-> engine_enable;
    endproperty

    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("pready missing after setup");
    a_ready_cause: assert property (p_ready_cause)
        else $error("pready without setup");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr without pready");
    a_bad_read: assert property (p_bad_read)
        else $error("unmapped read not refused");
    a_open_drain: assert property (p_open_drain)
        else $error("pin output not zero");
    a_byte_reply: assert property (p_byte_reply)
        else $error("byte reply without event");
    a_gc_reply: assert property (p_gc_reply)
        else $error("general call reply without event");
    a_nack_irx: assert property (p_nack_irx)
        else $error("nack outside interactive receive");
    a_role_en: assert property (p_role_en)
        else $error("engine control while disabled");
endmodule // twc_ctrl_chk

bind twc_ctrl twc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .sda_o, .scl_o, .eng_byte_rx, .eng_gc_seen, .engine_enable,
    .controller_role, .irx_active, .byte_reply_valid, .byte_reply_nack, .gc_reply_valid);

`default_nettype wire

// ---- test/tb_twc_ctrl.sv ----
// self-checking bench for the two-wire control block
`timescale 1ns/100ps
`default_nettype none
`include "twc_regs.vh"

module tb_twc_ctrl;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, c = 32'h0000_0000;
    logic        eng_sda_pull = 1'b0, eng_scl_pull = 1'b0, eng_byte_rx = 1'b0, eng_gc_seen = 1'b0;
    logic        far_sda_pull = 1'b0, far_scl_pull = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe;
    wire         engine_enable, controller_role, irx_active;
    wire         byte_reply_valid, byte_reply_nack, gc_reply_valid, gc_reply_ack;
    int          error_cnt = 0, n_checks = 0;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;

    always #4 pclk = ~pclk;

    twc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sda_i, .sda_o, .sda_oe, .scl_i, .scl_o, .scl_oe, .eng_sda_pull,
        .eng_scl_pull, .eng_byte_rx, .eng_gc_seen, .engine_enable, .controller_role,
        .irx_active, .byte_reply_valid, .byte_reply_nack, .gc_reply_valid, .gc_reply_ack);
    twc_bus_model u_bus (.sda_oe, .scl_oe, .far_sda_pull, .far_scl_pull, .sda_i, .scl_i);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one transfer, entered just after a rising edge; one idle cycle follows
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        input logic [31:0] ed, input logic err);
        int n;
        bit late;
        exp_q.push_back({err, w ? 32'h0000_0000 : ed});
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        late = (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
        if (late) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    function automatic logic [31:0] ctrl_rd(input logic [31:0] v);
        ctrl_rd = v & `TWC_CTRL_WMASK;
        ctrl_rd[`TWC_SDA_LVL_BIT] = !v[`TWC_SWPIN_BIT] || v[`TWC_SDA_OUT_BIT];
        ctrl_rd[`TWC_SCL_LVL_BIT] = !v[`TWC_SWPIN_BIT] || v[`TWC_SCL_OUT_BIT];
    endfunction

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_ffff_ffff;
            check({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_v);
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hb321));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `TWC_MAIN_CTRL_ADDR, 0, ctrl_rd(0), 1'b0);
        // software pin control off, bus idle, so bit3 may change
        repeat (6) begin
            c = $urandom & 32'hffff_fbff;
            xfer(1'b1, `TWC_MAIN_CTRL_ADDR, c, 0, 1'b0);
            repeat (4) @(posedge pclk);
            xfer(1'b0, `TWC_MAIN_CTRL_ADDR, 0, ctrl_rd(c), 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            c = 32'h0000_0400 | (i[1] << 7) | (i[0] << 6);
            xfer(1'b1, `TWC_MAIN_CTRL_ADDR, c, 0, 1'b0);
            repeat (3) @(posedge pclk);
            check({sda_oe, scl_oe}, {!c[7], !c[6]});
            xfer(1'b0, `TWC_MAIN_CTRL_ADDR, 0, ctrl_rd(c), 1'b0);
        end
        // drive fields low but engine owns the lines
        xfer(1'b1, `TWC_MAIN_CTRL_ADDR, 32'h0000_0001, 0, 1'b0);
        repeat (3) @(posedge pclk);
        check({sda_oe, scl_oe}, 2'b00);
        // engine pulls sda while scl is high: a start, the bus turns busy
        eng_sda_pull <= 1'b1;
        repeat (3) @(posedge pclk);
        check({sda_oe, scl_oe}, 2'b10);
        xfer(1'b0, `TWC_BUS_STATE_ADDR, 0, 32'h0000_0001, 1'b0);
        // interactive receive toggled mid-transfer is flagged
        xfer(1'b1, `TWC_MAIN_CTRL_ADDR, 32'h0000_0009, 0, 1'b0);
        xfer(1'b0, `TWC_BUS_STATE_ADDR, 0, 32'h0000_0003, 1'b0);
        // sda released while scl is high: a stop, the bus goes idle
        eng_sda_pull <= 1'b0;
        repeat (3) @(posedge pclk);
        check({sda_oe, scl_oe}, 2'b00);
        eng_scl_pull <= 1'b1;
        repeat (3) @(posedge pclk);
        check({sda_oe, scl_oe}, 2'b01);
        xfer(1'b0, `TWC_BUS_STATE_ADDR, 0, 32'h0000_0002, 1'b0);
        xfer(1'b1, `TWC_BUS_STATE_ADDR, 32'h0000_0002, 0, 1'b0);
        xfer(1'b0, `TWC_BUS_STATE_ADDR, 0, `TWC_STATE_RST, 1'b0);
        xfer(1'b1, `TWC_MAIN_CTRL_ADDR, 32'h0000_0000, 0, 1'b0);
        repeat (3) @(posedge pclk);
        check({sda_oe, scl_oe}, 2'b00);
        eng_scl_pull <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            c = i;
            xfer(1'b1, `TWC_MAIN_CTRL_ADDR, c, 0, 1'b0);
            repeat (2) @(posedge pclk);
            check({engine_enable, controller_role, irx_active},
                  {c[0], c[0] & c[1], c[0] & c[3]});
            eng_byte_rx <= 1'b1;
            eng_gc_seen <= 1'b1;
            @(posedge pclk);
            eng_byte_rx <= 1'b0;
            eng_gc_seen <= 1'b0;
            #1;
            check({byte_reply_valid, gc_reply_valid}, {2{c[0]}});
            if (c[0])
                check({byte_reply_nack, gc_reply_ack}, {c[3] & c[4], c[2]});
            @(posedge pclk);
        end
        xfer(1'b0, 12'h004, 0, 0, 1'b1);
        xfer(1'b1, 12'h004, 32'hffff_ffff, 0, 1'b1);
        xfer(1'b0, `TWC_BUS_STATE_ADDR, 0, `TWC_STATE_RST, 1'b0);
        xfer(1'b0, `TWC_MAIN_CTRL_ADDR, 0, ctrl_rd(c), 1'b0);
        // reset in mid-run clears every field again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({engine_enable, byte_reply_valid, sda_oe, scl_oe}, 4'h0);
        xfer(1'b0, `TWC_MAIN_CTRL_ADDR, 0, ctrl_rd(0), 1'b0);
        wrap_up();
    end
endmodule // tb_twc_ctrl

`default_nettype wire
